//--- mpks_cfg.svh
/*
  Constants for the module power key sequencer: key hold times, the clock
  rate and the state codes of the power state machine.
  Assumes it is included by bare name from the package and the design modules.
*/
`ifndef MPKS_CFG_SVH
`define MPKS_CFG_SVH

// ----------------------------------------------------------------------------
// Clock and key hold times
// ----------------------------------------------------------------------------
`define MPKS_CLK_HZ 200000000
`define MPKS_ON_HOLD_S 6
`define MPKS_OFF_HOLD_S 3
`define MPKS_WAKE_HOLD_S 5
`define MPKS_ON_HOLD_CYC (`MPKS_ON_HOLD_S * `MPKS_CLK_HZ)
`define MPKS_OFF_HOLD_CYC (`MPKS_OFF_HOLD_S * `MPKS_CLK_HZ)
`define MPKS_WAKE_HOLD_CYC (`MPKS_WAKE_HOLD_S * `MPKS_CLK_HZ)
`define MPKS_CNT_W 32

// ----------------------------------------------------------------------------
// One-hot state codes
// ----------------------------------------------------------------------------
`define MPKS_ST_OFF 6'h01
`define MPKS_ST_ON 6'h02
`define MPKS_ST_DETACH 6'h04
`define MPKS_ST_SLEEP 6'h08
`define MPKS_ST_RELEASE 6'h10
`define MPKS_ST_HALT 6'h20

`endif

//--- mpks_pkg.sv
/*
  Types shared by the module power key sequencer files.
  Assumes mpks_cfg.svh is on the include path.
*/
`include "mpks_cfg.svh"

package mpks_pkg;

  // --------------------------------------------------------------------------
  // Power states, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [5:0] {
    MPKS_OFF = `MPKS_ST_OFF,
    MPKS_ON = `MPKS_ST_ON,
    MPKS_DETACH = `MPKS_ST_DETACH,
    MPKS_SLEEP = `MPKS_ST_SLEEP,
    MPKS_RELEASE = `MPKS_ST_RELEASE,
    MPKS_HALT = `MPKS_ST_HALT
  } mpks_state_t;

endpackage

//--- mpks_hold_timer.sv
/*
  Hold timer: counts consecutive cycles of an active level and flags when
  the count has reached its limit. Any gap restarts the count.
  Assumes a single clock and an active low asynchronous reset.
*/
`timescale 1ns/1ps
`include "mpks_cfg.svh"

module mpks_hold_timer #(
  parameter int unsigned LIMIT = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Level to time and result
  input wire logic level,
  output logic reached
);

  logic [`MPKS_CNT_W-1:0] count_ff;

  initial begin
    if (LIMIT < 1) begin
      $error("mpks_hold_timer: LIMIT must be at least one");
    end
  end

  // Saturating count of the level; saturation avoids wrapping on a stuck key.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= '0;
    end else if (!level) begin
      count_ff <= '0;
    end else if (count_ff < LIMIT[`MPKS_CNT_W-1:0]) begin
      count_ff <= count_ff + 1'b1;
    end
  end

  assign reached = (count_ff >= LIMIT[`MPKS_CNT_W-1:0]);

endmodule

//--- mpks_sequencer.sv
/*
  Device side power key sequencer of a cellular modem module. It watches the
  active low open-drain power key line, keeps the power state, drives the
  power indicator and asks firmware to detach from the network.
  Assumes the key input is synchronous to clk and that firmware answers the
  detach request and signals power-saving timer expiry and wake-up.
*/

`timescale 1ns/1ps
`include "mpks_cfg.svh"

module mpks_sequencer
  import mpks_pkg::*;
#(
  parameter longint unsigned ON_HOLD_CYC = `MPKS_ON_HOLD_CYC,
  parameter longint unsigned OFF_HOLD_CYC = `MPKS_OFF_HOLD_CYC,
  parameter longint unsigned WAKE_HOLD_CYC = `MPKS_WAKE_HOLD_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Power key line, open drain, active low
  input wire logic power_key_n_in,
  output logic power_key_n_out,
  output logic power_key_n_oe_n,
  // Firmware requests
  input wire logic shutdown_command,
  input wire logic unconditional_shutdown,
  input wire logic psm_enable,
  input wire logic psm_timer_expired,
  input wire logic scheduled_wake,
  // Network detach handshake
  output logic detach_req,
  input wire logic detach_done,
  // Status
  output logic power_indicator,
  output logic baseband_reset,
  output mpks_pkg::mpks_state_t power_state
);

  import mpks_pkg::*;

  mpks_state_t state_ff;
  mpks_state_t nxt_state;
  logic key_low;
  logic on_level;
  logic off_level;
  logic wake_level;
  logic on_hold_hit;
  logic off_hold_hit;
  logic wake_hold_hit;
  logic power_indicator_ff;
  logic detach_req_ff;
  logic baseband_reset_ff;

  // Elaboration checks: every hold count must fit the 32 bit hold timer and
  // be at least one cycle, and a stop press must be shorter than a start
  // press so that one long press cannot be read as both.
  initial begin
    if (ON_HOLD_CYC < 1 || ON_HOLD_CYC > 64'h0000_0000_ffff_ffff) begin
      $error("mpks_sequencer: start hold count out of range");
    end
    if (OFF_HOLD_CYC < 1 || OFF_HOLD_CYC >= ON_HOLD_CYC) begin
      $error("mpks_sequencer: stop hold count out of range");
    end
    if (WAKE_HOLD_CYC < 1 || WAKE_HOLD_CYC > 64'h0000_0000_ffff_ffff) begin
      $error("mpks_sequencer: wake hold count out of range");
    end
  end

  // --------------------------------------------------------------------------
  // Key line
  // --------------------------------------------------------------------------
  // The device never drives the key; its pull-up is external to this logic.
  // The key is taken as synchronous and unfiltered, so a bounce restarts a hold.
  assign power_key_n_out = 1'b1;
  assign power_key_n_oe_n = 1'b1;
  assign key_low = !power_key_n_in;

  // --------------------------------------------------------------------------
  // Hold timers
  // --------------------------------------------------------------------------
  // Timers only run in the state where their hold means something, so a
  // press that began in another state is timed only from that state's entry.
  assign on_level = key_low && (state_ff == MPKS_OFF);
  assign off_level = key_low && (state_ff == MPKS_ON);
  assign wake_level = key_low && (state_ff == MPKS_SLEEP);

  mpks_hold_timer #(.LIMIT(`MPKS_CNT_W'(ON_HOLD_CYC))) u_on_timer (
    .clk(clk),
    .rst_n(rst_n),
    .level(on_level),
    .reached(on_hold_hit)
  );

  mpks_hold_timer #(.LIMIT(`MPKS_CNT_W'(OFF_HOLD_CYC))) u_off_timer (
    .clk(clk),
    .rst_n(rst_n),
    .level(off_level),
    .reached(off_hold_hit)
  );

  mpks_hold_timer #(.LIMIT(`MPKS_CNT_W'(WAKE_HOLD_CYC))) u_wake_timer (
    .clk(clk),
    .rst_n(rst_n),
    .level(wake_level),
    .reached(wake_hold_hit)
  );

  // --------------------------------------------------------------------------
  // Power state machine
  // --------------------------------------------------------------------------
  // Unconditional shutdown outranks everything in on and detach and is
  // ignored in every other state. After a key stop the machine waits for the key to be released
  // so that a long press cannot restart the module at once.
  // Firmware requests are looked at on every edge and are not queued: a
  // shutdown command that arrives outside the on state is simply dropped,
  // so firmware must repeat it once the module is on again.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      MPKS_OFF: begin
        if (on_hold_hit) begin
          nxt_state = MPKS_ON;
        end
      end
      MPKS_ON: begin
        if (unconditional_shutdown) begin
          nxt_state = MPKS_HALT;
        end else if (shutdown_command || off_hold_hit) begin
          nxt_state = MPKS_DETACH;
        end else if (psm_enable && psm_timer_expired) begin
          nxt_state = MPKS_SLEEP;
        end
      end
      MPKS_DETACH: begin
        if (unconditional_shutdown) begin
          nxt_state = MPKS_HALT;
        end else if (detach_done) begin
          nxt_state = MPKS_RELEASE;
        end
      end
      MPKS_SLEEP: begin
        if (wake_hold_hit || scheduled_wake) begin
          nxt_state = MPKS_ON;
        end
      end
      MPKS_HALT: begin
        nxt_state = MPKS_RELEASE;
      end
      MPKS_RELEASE: begin
        if (!key_low) begin
          nxt_state = MPKS_OFF;
        end
      end
      default: begin
        nxt_state = MPKS_OFF;
      end
    endcase
  end

  // State register; reset leaves the module switched off.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= MPKS_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Indicator is high in on and detach and low in off, sleep, halt and release.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_indicator_ff <= 1'b0;
    end else begin
      power_indicator_ff <= (nxt_state == MPKS_ON) || (nxt_state == MPKS_DETACH);
    end
  end

  // Detach request stands for the whole detach state, never during halt.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      detach_req_ff <= 1'b0;
    end else begin
      detach_req_ff <= (nxt_state == MPKS_DETACH);
    end
  end

  // Baseband reset is held in halt and in off, so all activity stops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baseband_reset_ff <= 1'b1;
    end else begin
      baseband_reset_ff <= (nxt_state != MPKS_ON) && (nxt_state != MPKS_DETACH);
    end
  end

  // Data outputs come straight from their flip-flops, so they change on the
  // same edge as the state and never glitch.
  assign power_indicator = power_indicator_ff;
  assign detach_req = detach_req_ff;
  assign baseband_reset = baseband_reset_ff;
  assign power_state = state_ff;

endmodule

//--- mpks_chk.sv
/* Port checker for mpks_sequencer.
   Assumes one clock domain and is bound to every sequencer instance. */
`timescale 1ns/1ps
module mpks_chk
  import mpks_pkg::*;
(
  // Clock, reset and requests
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_key_n_in,
  input wire logic shutdown_command,
  input wire logic unconditional_shutdown,
  input wire logic psm_enable,
  input wire logic psm_timer_expired,
  input wire logic detach_done,
  // Outputs watched
  input wire logic detach_req,
  input wire logic power_indicator,
  input wire logic baseband_reset,
  input wire mpks_state_t power_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Key released and no shutdown command, so a state move has one cause only.
  logic calm;
  assign calm = power_key_n_in && !shutdown_command;
  a_ind_powered: assert property (
    power_indicator == (power_state inside {MPKS_ON, MPKS_DETACH})) else $error("Indicator bad.");
  a_sleep_dark: assert property (
    power_state == MPKS_SLEEP |-> !power_indicator) else $error("Lit in sleep.");
  a_detach_level: assert property (
    detach_req == (power_state == MPKS_DETACH)) else $error("Detach request bad.");
  a_bbr_level: assert property (
    baseband_reset == !(power_state inside {MPKS_ON, MPKS_DETACH})) else $error("Reset level bad.");
  // An emergency stop may cut a detach short, so both detach checks exclude it.
  a_detach_wait: assert property (
    power_state == MPKS_DETACH && !detach_done && !unconditional_shutdown
    |=> power_state == MPKS_DETACH) else $error("Left detach early.");
  a_detach_exit: assert property (
    power_state == MPKS_DETACH && detach_done && !unconditional_shutdown
    |=> power_state == MPKS_RELEASE && !power_indicator) else $error("Detach exit bad.");
  a_halt_direct: assert property (
    power_state == MPKS_ON && unconditional_shutdown && calm
    |=> power_state == MPKS_HALT && baseband_reset && !detach_req) else $error("Halt bad.");
  a_sleep_nohalt: assert property (
    power_state == MPKS_SLEEP |=> power_state != MPKS_HALT) else $error("Halt from sleep.");
  // A key let go in this cycle may still complete a stop press, so the key
  // must have been high one cycle earlier as well.
  a_psm_entry: assert property (
    power_state == MPKS_ON && psm_enable && psm_timer_expired && calm && !unconditional_shutdown
    && $past(power_key_n_in) |=> power_state == MPKS_SLEEP) else $error("No sleep entry.");
endmodule
bind mpks_sequencer mpks_chk mpks_chk_i (.clk(clk), .rst_n(rst_n),
  .power_key_n_in(power_key_n_in), .shutdown_command(shutdown_command),
  .unconditional_shutdown(unconditional_shutdown), .psm_enable(psm_enable),
  .psm_timer_expired(psm_timer_expired), .detach_done(detach_done), .detach_req(detach_req),
  .power_indicator(power_indicator), .baseband_reset(baseband_reset), .power_state(power_state));

//--- mpks_host_model.sv
/* Host side key driver model.
   Assumes the device pull-up makes the released line read high. */
`timescale 1ns/1ps
module mpks_host_model (
  // Press request and key line
  input wire logic press,
  output logic key_n
);
  // Open drain only: a released key reads high through the device pull-up,
  // so the high level here stands for that pull-up, not a host drive.
  assign key_n = press ? 1'b0 : 1'b1;
endmodule

//--- tb_top.sv
/* Self-checking bench for mpks_sequencer.
   Assumes short hold counts so that each press lasts tens of cycles. */
`timescale 1ns/1ps
module tb_top;
  import mpks_pkg::*;
  localparam int ON_C = 20;
  localparam int OFF_C = 10;
  localparam int WAKE_C = 15;
  logic clk = 0, rst_n = 0, press = 0, key_n, shut = 0, unc = 0, psm = 0, tmo = 0;
  logic wake = 0, done = 0, dreq, ind, bbr, kout, koe;
  mpks_state_t st;
  int err_count = 0, checks_done = 0;
  // Clock of 5 ns.
  initial begin
    forever #2.5 clk = ~clk;
  end
  mpks_host_model mpks_host_model_i (.press(press), .key_n(key_n));
  mpks_sequencer #(.ON_HOLD_CYC(ON_C), .OFF_HOLD_CYC(OFF_C), .WAKE_HOLD_CYC(WAKE_C))
  mpks_sequencer_i (.clk(clk), .rst_n(rst_n), .power_key_n_in(key_n), .power_key_n_out(kout),
    .power_key_n_oe_n(koe), .shutdown_command(shut), .unconditional_shutdown(unc),
    .psm_enable(psm), .psm_timer_expired(tmo), .scheduled_wake(wake), .detach_req(dreq),
    .detach_done(done), .power_indicator(ind), .baseband_reset(bbr), .power_state(st));
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_bit(logic got, logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: flag mismatch", $time);
    end
  endtask
  task automatic chk_st(mpks_state_t exp);
    checks_done++;
    if (st !== exp) begin
      err_count++;
      $display("Error %0t: state mismatch", $time);
    end
  endtask
  // Bounded waits, so a stuck sequencer is reported, not hung on.
  task automatic wait_st(mpks_state_t tgt);
    for (int i = 0; i < 40 && st !== tgt; i++) step(1);
    chk_st(tgt);
  endtask
  // Holds the key until the target state shows; the hold must be at least min_c.
  task automatic hold_key(mpks_state_t tgt, int min_c);
    int n;
    n = 0;
    press = 1;
    while (st !== tgt && n < 200) begin
      step(1);
      n++;
    end
    press = 0;
    chk_bit(n >= min_c && n <= min_c + 4, 1'b1);
    chk_st(tgt);
    // Let one edge pass with the key released before any further press.
    step(1);
  endtask
  task automatic t_on();
    press = 1;
    step(ON_C - 2);
    press = 0;
    step(2);
    chk_st(MPKS_OFF);
    hold_key(MPKS_ON, ON_C);
    chk_bit(ind, 1'b1);
    chk_bit(bbr, 1'b0);
    chk_bit(kout, 1'b1);
    chk_bit(koe, 1'b1);
  endtask
  task automatic t_detach();
    chk_bit(dreq, 1'b1);
    step(3);
    chk_st(MPKS_DETACH);
    done = 1;
    step(1);
    done = 0;
    wait_st(MPKS_OFF);
    chk_bit(ind, 1'b0);
    chk_bit(dreq, 1'b0);
  endtask
  task automatic t_off_key();
    hold_key(MPKS_DETACH, OFF_C);
    t_detach();
  endtask
  task automatic t_off_cmd();
    shut = 1;
    step(1);
    shut = 0;
    chk_st(MPKS_DETACH);
    t_detach();
  endtask
  task automatic t_uncond();
    unc = 1;
    step(1);
    unc = 0;
    chk_st(MPKS_HALT);
    chk_bit(dreq, 1'b0);
    chk_bit(bbr, 1'b1);
    wait_st(MPKS_OFF);
  endtask
  task automatic t_sleep();
    psm = 1;
    tmo = 1;
    step(1);
    tmo = 0;
    chk_st(MPKS_SLEEP);
    chk_bit(ind, 1'b0);
    unc = 1;
    step(2);
    unc = 0;
    chk_st(MPKS_SLEEP);
    hold_key(MPKS_ON, WAKE_C);
    tmo = 1;
    step(1);
    tmo = 0;
    chk_st(MPKS_SLEEP);
    wake = 1;
    step(1);
    wake = 0;
    wait_st(MPKS_ON);
    psm = 0;
  endtask
  task automatic test_done();
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    step(10);
    rst_n = 1;
    step(1);
    t_on();
    t_off_key();
    t_on();
    t_off_cmd();
    t_on();
    t_uncond();
    t_on();
    t_sleep();
    t_off_cmd();
    test_done();
  end
  // Whole run is well under 1000 cycles.
  initial begin
    #20000;
    err_count++;
    test_done();
  end
endmodule
